// File: logic/scan_tap_regs.svh
// Purpose: constants for the boundary-scan test port
// Assumes: included by the tap module and by the testbench
// Notes: instruction codes are parameters in the module; these are defaults
`ifndef SCAN_TAP_REGS_SVH
`define SCAN_TAP_REGS_SVH
`define TAP_IR_WIDTH 3
`define TAP_IR_CAPTURE 2'h1
`define TAP_OP_EXTEST 3'h0
`define TAP_OP_IDCODE 3'h1
`define TAP_OP_SAMPLEZ 3'h2
`define TAP_OP_SAMPLE 3'h4
`define TAP_OP_BYPASS 3'h7
`define TAP_ID_WIDTH 32
`define TAP_BSR_X36 73
`define TAP_BSR_X18 54
`define TAP_RESET_ONES 5
`endif

// File: logic/scan_tap_pkg.sv
// Purpose: types for the boundary-scan test port
// Assumes: nothing
// Notes: one-hot controller state codes
package scan_tap_pkg;
   typedef enum logic [15:0] {
      ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008, ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020,
      ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080, ST_UP_DR = 16'h0100,
      ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
      ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000,
      ST_UP_IR = 16'h8000
   } tap_state_e;
   typedef enum logic [2:0] {
      PATH_BYP = 3'h1, PATH_ID = 3'h2, PATH_BSR = 3'h4
   } scan_path_e;
endpackage

// File: logic/scan_tap.sv
// Purpose: boundary-scan test access port for a pipelined memory
// Assumes: test clock is much slower than ref_clk_in and sampled by it
// Notes: reads the pin ring snapshot; touches no memory signal except the outputs_hiz_out float request
// How it works
// R1 - sample on test clock rise, drive on fall
// R2 - mode select steers controller each rising edge
// R3 - data in enters selected register MSB
// R4 - data out shows selected register LSB
// R5 - data out driven only in shift states
// R6 - five mode-select-high edges force reset state
// R7 - test reset never touches memory operation
// R8 - power-up reset leaves data out floating
// R9 - exactly one register selected by instruction
// R10 - three-bit instruction, loaded only in IR path
// R11 - reset forces the identification instruction
// R12 - IR capture loads 01 into low bits
// R13 - undriven data in and mode select read high
// R14 - unused port: clock low, output unconnected
// R15 - new instruction takes effect at IR update
// R16 - bypass is one bit capturing low
// R17 - identification register captures hardwired code
// R18 - boundary register 73 or 54 bits long
// R19 - sixteen standard controller states and transitions
// R20 - instruction codes are parameters, reserved selects bypass
`include "scan_tap_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module scan_tap import scan_tap_pkg::*; #(
   parameter int BSR_LEN = `TAP_BSR_X36,
   parameter logic [31:0] ID_CODE = 32'h0000_0001, // arbitrary value
   parameter logic [2:0] OP_EXTEST = `TAP_OP_EXTEST,
   parameter logic [2:0] OP_IDCODE = `TAP_OP_IDCODE,
   parameter logic [2:0] OP_SAMPLEZ = `TAP_OP_SAMPLEZ,
   parameter logic [2:0] OP_SAMPLE = `TAP_OP_SAMPLE,
   parameter logic [2:0] OP_BYPASS = `TAP_OP_BYPASS
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   input wire logic [BSR_LEN-1:0] pin_ring_in,
   output logic tdo_out,
   output logic tdo_oe_out,
   output logic outputs_hiz_out
);
   localparam int IRW = `TAP_IR_WIDTH;

   // scan path chosen by an instruction; unknown codes fall to bypass
   function automatic scan_path_e path_of(input logic [IRW-1:0] op);
      if (op == OP_IDCODE) return PATH_ID; // R20
      if (op == OP_EXTEST || op == OP_SAMPLEZ || op == OP_SAMPLE) return PATH_BSR;
      return PATH_BYP; // R20
   endfunction

   //////////////////////////////////////////////////////////////////////
   // pin synchronisers; pull-ups assumed at the pad so floating reads 1
   logic [1:0] tck_s_r, tms_s_r, tdi_s_r;
   logic tck_d_r;
   logic [1:0] tck_s_nxt, tms_s_nxt, tdi_s_nxt;
   always_comb begin
      tck_s_nxt = {tck_s_r[0], tck_in};
      tms_s_nxt = {tms_s_r[0], tms_in}; // R13
      tdi_s_nxt = {tdi_s_r[0], tdi_in}; // R13
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tck_s_r <= 2'h0;
         tms_s_r <= 2'h3;
         tdi_s_r <= 2'h3;
         tck_d_r <= 1'b0;
      end else begin
         tck_s_r <= tck_s_nxt;
         tms_s_r <= tms_s_nxt;
         tdi_s_r <= tdi_s_nxt;
         tck_d_r <= tck_s_r[1];
      end
   end
   wire logic tck_rise = tck_s_r[1] & ~tck_d_r; // R1
   wire logic tck_fall = ~tck_s_r[1] & tck_d_r; // R1

   //////////////////////////////////////////////////////////////////////
   // controller, instruction and data registers
   tap_state_e st_r, st_nxt;
   logic [IRW-1:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
   logic byp_r, byp_nxt;
   logic [`TAP_ID_WIDTH-1:0] id_r, id_nxt;
   logic [BSR_LEN-1:0] bsr_r, bsr_nxt;
   logic tdo_r, tdo_nxt, oe_r, oe_nxt, hiz_r, hiz_nxt;
   scan_path_e path;

   // next state per standard diagram; five ones reach reset from anywhere
   always_comb begin
      logic m;
      m = tms_s_r[1];
      st_nxt = st_r;
      if (tck_rise) begin // R2
         case (st_r) // R19
            ST_RESET: st_nxt = m ? ST_RESET : ST_IDLE; // R6
            ST_IDLE: st_nxt = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: st_nxt = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_nxt = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: st_nxt = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: st_nxt = m ? ST_UP_DR : ST_PA_DR;
            ST_PA_DR: st_nxt = m ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: st_nxt = m ? ST_UP_DR : ST_SH_DR;
            ST_UP_DR: st_nxt = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: st_nxt = m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: st_nxt = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: st_nxt = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: st_nxt = m ? ST_UP_IR : ST_PA_IR;
            ST_PA_IR: st_nxt = m ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: st_nxt = m ? ST_UP_IR : ST_SH_IR;
            ST_UP_IR: st_nxt = m ? ST_SEL_DR : ST_IDLE;
            default: st_nxt = ST_RESET;
         endcase
      end
   end

   // shifts on rise; outputs move on fall so the tester samples stable data
   always_comb begin
      path = path_of(ir_r); // R9
      ir_sh_nxt = ir_sh_r;
      ir_nxt = ir_r;
      byp_nxt = byp_r;
      id_nxt = id_r;
      bsr_nxt = bsr_r;
      tdo_nxt = tdo_r;
      oe_nxt = oe_r;
      hiz_nxt = hiz_r;
      if (tck_rise) begin
         case (st_r)
            ST_RESET: ir_nxt = OP_IDCODE; // R11
            ST_CAP_IR: ir_sh_nxt = {ir_sh_r[IRW-1:2], `TAP_IR_CAPTURE}; // R12
            ST_SH_IR: ir_sh_nxt = {tdi_s_r[1], ir_sh_r[IRW-1:1]}; // R3 R10
            ST_UP_IR: ir_nxt = ir_sh_r; // R15
            ST_CAP_DR: begin
               byp_nxt = 1'b0; // R16
               if (path == PATH_ID) id_nxt = ID_CODE; // R17
               if (path == PATH_BSR) bsr_nxt = pin_ring_in; // R18
            end
            ST_SH_DR: begin
               case (path) // R9
                  PATH_ID: id_nxt = {tdi_s_r[1], id_r[`TAP_ID_WIDTH-1:1]}; // R3
                  PATH_BSR: bsr_nxt = {tdi_s_r[1], bsr_r[BSR_LEN-1:1]}; // R3
                  default: byp_nxt = tdi_s_r[1]; // R16
               endcase
            end
            default: ;
         endcase
         // reload on entry, not one rise later, so the next fall already sees idcode
         if (st_nxt == ST_RESET) ir_nxt = OP_IDCODE; // R11
      end
      if (tck_fall) begin // R1
         oe_nxt = (st_r == ST_SH_DR) || (st_r == ST_SH_IR); // R5
         if (st_r == ST_SH_IR) tdo_nxt = ir_sh_r[0]; // R4
         else if (path == PATH_ID) tdo_nxt = id_r[0]; // R4
         else if (path == PATH_BSR) tdo_nxt = bsr_r[0];
         else tdo_nxt = byp_r;
         // memory outputs float under extest and sample-z only
         hiz_nxt = (ir_r == OP_EXTEST) || (ir_r == OP_SAMPLEZ);
      end
   end

   // own reset only; memory datapath is never reset from here
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin // R8 R7
         st_r <= ST_RESET;
         ir_sh_r <= `TAP_OP_IDCODE;
         ir_r <= `TAP_OP_IDCODE; // R11
         byp_r <= 1'b0;
         id_r <= '0;
         bsr_r <= '0;
         tdo_r <= 1'b0;
         oe_r <= 1'b0; // R8
         hiz_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         ir_sh_r <= ir_sh_nxt;
         ir_r <= ir_nxt;
         byp_r <= byp_nxt;
         id_r <= id_nxt;
         bsr_r <= bsr_nxt;
         tdo_r <= tdo_nxt;
         oe_r <= oe_nxt;
         hiz_r <= hiz_nxt;
      end
   end
   assign tdo_out = tdo_r;
   assign tdo_oe_out = oe_r;
   assign outputs_hiz_out = hiz_r;

   //////////////////////////////////////////////////////////////////////
   // checks
   // each check looks one reference edge after the tap event that it follows
   chk_reset_ir: assert property ( // R11
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      st_r == ST_RESET && tck_rise |=> ir_r == OP_IDCODE)
      else $error("ir not idcode");
   chk_oe_fall: assert property ( // R1
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      $changed(oe_r) |-> $past(tck_fall))
      else $error("oe moved off fall");
   chk_oe_shift: assert property ( // R5
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      tck_fall && !(st_r inside {ST_SH_DR, ST_SH_IR}) |=> !oe_r)
      else $error("oe bad");
   chk_ir_capture: assert property ( // R12
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      st_r == ST_CAP_IR && tck_rise |=> ir_sh_r[1:0] == `TAP_IR_CAPTURE)
      else $error("ir capture");
   // reset entry reloads the instruction too, so only update-ir or reset may move it
   chk_ir_update: assert property ( // R15
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      $changed(ir_r) |-> $past(st_r) == ST_UP_IR || st_r == ST_RESET)
      else $error("ir early");
   chk_tms_reset: assert property ( // R6
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      tck_rise && tms_s_r[1] && st_r == ST_SEL_IR |=> st_r == ST_RESET)
      else $error("no reset");
   chk_byp_cap: assert property ( // R16
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      st_r == ST_CAP_DR && tck_rise |=> !byp_r)
      else $error("bypass capture");
   chk_id_cap: assert property ( // R17
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      st_r == ST_CAP_DR && tck_rise && ir_r == OP_IDCODE |=> id_r == ID_CODE)
      else $error("id capture");
   cov_tms_reset: cover property (@(posedge ref_clk_in) st_r == ST_SEL_IR && tck_rise && tms_s_r[1]);
   cov_ir_shift: cover property (@(posedge ref_clk_in) st_r == ST_SH_IR && tck_rise);
   cov_dr_shift: cover property (@(posedge ref_clk_in) st_r == ST_SH_DR && tck_rise);
   cov_upd_ir: cover property (@(posedge ref_clk_in) st_r == ST_UP_IR && tck_rise);
endmodule // scan_tap
`default_nettype wire

// File: dv/jtag_ctrl_model.sv
// Purpose: test controller model driving the scan port
// Assumes: bench calls step once per test clock period
// Notes: tck is 8 ref clocks, parked low between frames
`timescale 1ns/100ps
`default_nettype none
module jtag_ctrl_model (
   input wire logic ref_clk_in,
   input wire logic tdo_in,
   input wire logic tdo_oe_in,
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out
);
   logic last_r;
   // parked levels: clock low, lines high
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b1;
      last_r = 1'b0;
   end
   ///////////////////////////////////
   // levels held 4 clocks each side of the rise
   task automatic step(input logic ms, input logic di, output logic o, output logic oe);
      tms_out <= ms;
      tdi_out <= di;
      repeat (4) @(posedge ref_clk_in);
      tck_out <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      #1;
      oe = tdo_oe_in;
      // a floating output reads as the inverse of its last level
      o = oe ? tdo_in : ~last_r;
      last_r = o;
      repeat (2) @(posedge ref_clk_in);
      tck_out <= 1'b0;
   endtask
endmodule // jtag_ctrl_model
`default_nettype wire

// File: dv/testbench.sv
// Purpose: self-checking bench for the scan test port
// Assumes: default opcodes; identification code set by the bench
// Notes: rows cover all eight opcodes; resets by hand
`include "scan_tap_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
   typedef struct {logic [2:0] op; int len; logic hiz;} row_s;
   localparam int BSR = `TAP_BSR_X36;
   localparam logic [BSR-1:0] RING = 73'h1A5A5C3C30FF012349;
   localparam logic [31:0] IDC = 32'h5A3C_0F0B; // arbitrary value
   localparam logic [7:0] PAT = 8'hA5;
   logic ref_clk_in, rst_n_in, tck, tms, tdi, tdo_out, tdo_oe_out, outputs_hiz_out;
   logic cur_hiz, t, oe;
   logic [127:0] got;
   logic [BSR-1:0] ring;
   int error_cnt = 0;
   int comparisons = 0;
   row_s rows [8] = '{'{`TAP_OP_EXTEST, BSR, 1'b1}, '{`TAP_OP_IDCODE, 32, 1'b0},
      '{`TAP_OP_SAMPLEZ, BSR, 1'b1}, '{3'h3, 1, 1'b0}, '{`TAP_OP_SAMPLE, BSR, 1'b0},
      '{3'h5, 1, 1'b0}, '{3'h6, 1, 1'b0}, '{`TAP_OP_BYPASS, 1, 1'b0}};
   scan_tap #(.BSR_LEN(BSR), .ID_CODE(IDC)) i_scan_tap (.ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .pin_ring_in(ring),
      .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .outputs_hiz_out(outputs_hiz_out));
   jtag_ctrl_model i_jtag_ctrl_model (.ref_clk_in(ref_clk_in), .tdo_in(tdo_out),
      .tdo_oe_in(tdo_oe_out), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
   ///////////////////////////////////
   task automatic end_sim();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk_vec(input logic [127:0] g, input logic [127:0] e);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk_vec({127'h0, g}, {127'h0, e});
   endtask
   // mode-select walk, lsb first, data line high; clock parks low until the last fall lands
   task automatic walk(input logic [15:0] ms, input int n);
      for (int i = 0; i < n; i++) i_jtag_ctrl_model.step(ms[i], 1'b1, t, oe);
      repeat (4) @(posedge ref_clk_in);
   endtask
   // from reset or idle into shift-ir, load, update, back to idle
   task automatic ir_load(input logic [2:0] op);
      walk(16'h0006, 5);
      for (int i = 0; i < 3; i++) begin
         i_jtag_ctrl_model.step(i == 2, op[i], t, oe);
         if (i < 2) chk_bit(t, i == 0);
         chk_bit(oe, 1'b1);
      end
      chk_bit(outputs_hiz_out, cur_hiz);
      walk(16'h0001, 2);
      cur_hiz = (op == `TAP_OP_EXTEST) || (op == `TAP_OP_SAMPLEZ);
      chk_bit(outputs_hiz_out, cur_hiz);
   endtask
   // capture then shift n bits, pattern following the captured value
   task automatic dr_scan(input int n);
      walk(16'h0001, 3);
      got = '0;
      for (int i = 0; i < n; i++) begin
         i_jtag_ctrl_model.step(i == n - 1, PAT[i % 8], t, oe);
         got[i] = t;
      end
      walk(16'h0001, 2);
   endtask
   function automatic logic [127:0] expv(input int n);
      return (128'(PAT) << n) | (n == 1 ? 128'h0 : n == 32 ? 128'(IDC) : 128'(ring));
   endfunction
   task automatic id_check();
      cur_hiz = 1'b0;
      walk(16'h0000, 1);
      dr_scan(`TAP_ID_WIDTH + 8);
      chk_vec(got, expv(`TAP_ID_WIDTH));
   endtask
   // 20 MHz reference clock
   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   // generous bound, the run needs about a quarter of it
   initial begin
      #1000000;
      error_cnt++;
      end_sim();
   end
   initial begin
      rst_n_in = 1'b0;
      ring = RING;
      cur_hiz = 1'b0;
      repeat (8) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      chk_bit(tdo_oe_out, 1'b0);
      foreach (rows[k]) begin
         ir_load(rows[k].op);
         chk_bit(outputs_hiz_out, rows[k].hiz);
         // flip the ring on one boundary row so a stale capture shows
         ring <= k[1] ? ~RING : RING;
         dr_scan(rows[k].len + 8);
         chk_vec(got, expv(rows[k].len));
      end
      // five high edges from shift-dr land in reset
      ir_load(`TAP_OP_EXTEST);
      walk(16'h0001, 3);
      chk_bit(tdo_oe_out, 1'b1);
      walk(16'h001F, `TAP_RESET_ONES);
      chk_bit(tdo_oe_out, 1'b0);
      chk_bit(outputs_hiz_out, 1'b0);
      id_check();
      // asynchronous reset in mid shift
      ir_load(`TAP_OP_SAMPLEZ);
      walk(16'h0001, 3);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      chk_bit(tdo_oe_out, 1'b0);
      chk_bit(outputs_hiz_out, 1'b0);
      rst_n_in <= 1'b1;
      id_check();
      end_sim();
   end
endmodule // testbench
`default_nettype wire
